//--- dv/fifo_side_model.sv
/* Model of the receive and transmit FIFOs beside the register block.
   Assumes the bench requests arrivals and drains between clock edges. */
`timescale 1ns/100ps
module fifo_side_model (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        rx_pop_i,
	input  wire logic        tx_push_i,
	input  wire logic        rx_reset_i,
	input  wire logic        tx_reset_i,
	input  wire logic        put_i,
	input  wire logic [10:0] put_char_i,
	input  wire logic        drain_i,
	output logic      [4:0]  rx_level_o,
	output logic             rx_push_o,
	output logic      [7:0]  head_data_o,
	output logic      [2:0]  head_err_o,
	output logic             any_err_o,
	output logic             overrun_o,
	output logic             tx_empty_o,
	output logic             shift_empty_o
);
	// =============================================================
	// Receive and transmit state
	logic [10:0] q[$];
	logic        tog = 1'b0;
	int          txc;
	logic        sh;
	// Sixteen-deep receive queue; an empty head shows a changing pattern.
	always @(posedge ref_clk_i) begin : rx_side
		logic e;
		e = 1'b0;
		rx_push_o <= 1'b0;
		overrun_o <= 1'b0;
		tog <= ~tog;
		if (rst_i || rx_reset_i) begin
			q.delete();
		end else begin
			if (rx_pop_i && q.size() > 0) void'(q.pop_front());
			if (put_i && q.size() < 16) begin
				q.push_back(put_char_i);
				rx_push_o <= 1'b1;
			end else if (put_i) begin
				overrun_o <= 1'b1;
			end
		end
		foreach (q[i]) e |= |q[i][10:8];
		any_err_o <= e;
		rx_level_o <= 5'(q.size());
		head_data_o <= q.size() ? q[0][7:0] : {8{tog}};
		head_err_o <= q.size() ? q[0][10:8] : 3'h0;
	end
	// Transmit FIFO count and shift register occupancy.
	always @(posedge ref_clk_i) begin
		if (rst_i || tx_reset_i) begin
			txc = 0;
			sh = 1'b0;
		end else begin
			if (drain_i) sh = txc > 0;
			if (drain_i && txc > 0) txc--;
			if (tx_push_i) txc++;
		end
		tx_empty_o <= txc == 0;
		shift_empty_o <= txc == 0 && !sh;
	end
endmodule

//--- dv/uart_ier_regs_chk.sv
/* Port checker for the interrupt-enable register block.
   Assumes it is bound to uart_ier_regs and sees only its ports. */
`timescale 1ns/100ps
module uart_ier_regs_chk (
	input wire logic       ref_clk_i,
	input wire logic       rst_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [4:0] rx_level_i,
	input wire logic       rx_pop_o,
	input wire logic       tx_push_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       rx_fifo_reset_o,
	input wire logic       fifo_enable_o,
	input wire logic       sleep_enable_o,
	input wire logic [7:0] flow_ctrl_o,
	input wire logic       irq_o
);
	// =============================================================
	// Shadow registers
	logic [7:0] lcr_r;
	logic [7:0] efr_r;
	logic [3:0] ier_r;
	logic [1:0] trg_r;
	logic [4:0] trig;
	wire        plain = !lcr_r[7];
	// Follows host writes to the control registers.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			lcr_r <= 8'h00;
			efr_r <= 8'h00;
			ier_r <= 4'h0;
			trg_r <= 2'h0;
		end else if (wr_i) begin
			if (addr_i == 3'h3) lcr_r <= wdata_i;
			if (addr_i == 3'h2 && lcr_r == 8'hbf) efr_r <= wdata_i;
			if (addr_i == 3'h1 && plain) ier_r <= wdata_i[3:0];
			if (addr_i == 3'h2 && plain) trg_r <= wdata_i[0] ? wdata_i[7:6] : 2'h0;
		end
	end
	// Decodes the receive trigger level.
	always_comb begin
		case (trg_r)
			2'h0: trig = 5'h01;
			2'h1: trig = 5'h04;
			2'h2: trig = 5'h08;
			default: trig = 5'h0e;
		endcase
	end
	// =============================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_pop_on_read: assert property (
		rx_pop_o == (rd_i && addr_i == 3'h0 && plain)) else $error("pop mismatch");
	a_push_on_write: assert property (
		tx_push_o == (wr_i && addr_i == 3'h0 && plain) && (!tx_push_o || tx_data_o == wdata_i))
		else $error("push mismatch");
	a_sleep_needs_enh: assert property (sleep_enable_o |-> efr_r[4])
		else $error("sleep without enhanced bit");
	a_flow_reg_map: assert property (flow_ctrl_o == efr_r)
		else $error("enhanced register mismatch");
	a_irq_all_masked: assert property (ier_r == 4'h0 |-> !irq_o)
		else $error("masked interrupt raised");
	a_rx_plain_irq: assert property (
		(ier_r == 4'h1 && !fifo_enable_o) |-> irq_o == (rx_level_i != 5'h00))
		else $error("receive interrupt mismatch");
	a_rx_trig_irq: assert property (
		(ier_r == 4'h1 && fifo_enable_o) |-> irq_o == (rx_level_i >= trig))
		else $error("trigger interrupt mismatch");
	a_reset_state: assert property (disable iff (1'b0)
		rst_i |=> rdata_o == 8'h00 && !irq_o && flow_ctrl_o == 8'h00 && !fifo_enable_o)
		else $error("reset state mismatch");
	a_fifo_ctrl_write: assert property (
		(wr_i && addr_i == 3'h2 && plain) |=> fifo_enable_o == $past(wdata_i[0])
		&& rx_fifo_reset_o == $past(wdata_i[0] & wdata_i[1])) else $error("fifo control mismatch");
	c_pop: cover property (rx_pop_o);
	c_trig_irq: cover property (irq_o && fifo_enable_o);
	c_sleep: cover property (sleep_enable_o);
endmodule

//--- dv/uart_ier_regs_tb.sv
/* Self-checking bench for the interrupt-enable register block.
   Assumes the FIFO model answers on the far side. */
`timescale 1ns/100ps
module uart_ier_regs_tb;
	// =============================================================
	// Signals and bench model state
	logic        ref_clk_i, rst_i, wr_i, rd_i, put_i, drain_i;
	logic [2:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, v, tx_data_o, flow_ctrl_o, fc[8], head;
	logic [3:0]  modem_delta_i, modem_state_i;
	logic [4:0]  lvl;
	logic [2:0]  herr;
	logic [10:0] put_char_i;
	logic        push, anyerr, ovrp, txe, she, pop, txp, rxr, txr, fen, slp, tick, irq_o;
	int          fail_count, checked, cycles, i, k, n, txc, seed = 32'h731a;
	int          rq[$];
	int          tl[4] = '{1, 4, 8, 14};
	logic        ovr, sh;
	uart_ier_regs u_uart_ier_regs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_level_i(lvl),
		.rx_push_i(push), .rx_head_data_i(head), .rx_head_parity_i(herr[0]),
		.rx_head_framing_i(herr[1]), .rx_head_break_i(herr[2]), .rx_any_error_i(anyerr),
		.rx_overrun_i(ovrp), .tx_fifo_empty_i(txe), .tx_shift_empty_i(she),
		.modem_delta_i(modem_delta_i), .modem_state_i(modem_state_i), .rx_pop_o(pop),
		.tx_push_o(txp), .tx_data_o(tx_data_o), .rx_fifo_reset_o(rxr), .tx_fifo_reset_o(txr),
		.fifo_enable_o(fen), .sleep_enable_o(slp), .baud_tick_o(tick),
		.flow_ctrl_o(flow_ctrl_o), .irq_o(irq_o));
	fifo_side_model u_fifo_side_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rx_pop_i(pop),
		.tx_push_i(txp), .rx_reset_i(rxr), .tx_reset_i(txr), .put_i(put_i),
		.put_char_i(put_char_i), .drain_i(drain_i), .rx_level_o(lvl), .rx_push_o(push),
		.head_data_o(head), .head_err_o(herr), .any_err_o(anyerr), .overrun_o(ovrp),
		.tx_empty_o(txe), .shift_empty_o(she));
	// Clock and cycle ceiling.
	always #10 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// =============================================================
	// Tasks
	task automatic cyc(int c);
		repeat (c) @(negedge ref_clk_i);
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		cyc(1);
		wr_i = 1'b0;
	endtask
	task automatic chk(string what, logic [7:0] e, logic [7:0] s);
		checked++;
		if (e !== s) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic rdc(logic [2:0] a, logic [7:0] e);
		addr_i = a;
		rd_i = 1'b1;
		cyc(1);
		rd_i = 1'b0;
		chk($sformatf("register %0d", a), e, rdata_o);
	endtask
	task automatic put(logic [10:0] c);
		put_i = 1'b1;
		put_char_i = c;
		cyc(1);
		put_i = 1'b0;
		cyc(1);
		if (rq.size() < 16) rq.push_back(c);
		else ovr = 1'b1;
	endtask
	task automatic pop_one();
		rdc(3'h0, rq[0][7:0]);
		void'(rq.pop_front());
	endtask
	task automatic drain();
		drain_i = 1'b1;
		cyc(1);
		drain_i = 1'b0;
		sh = txc > 0;
		if (txc > 0) txc--;
		cyc(2);
	endtask
	// Expected line status from the bench queue and transmit count.
	function automatic logic [7:0] lsr_e();
		logic ae = 1'b0;
		foreach (rq[j]) ae |= rq[j][10:8] != 0;
		return {ae, txc == 0 && !sh, txc == 0, rq.size() ? rq[0][10:8] : 3'h0, ovr, rq.size() != 0};
	endfunction
	task automatic tally_and_finish();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// =============================================================
	// Main sequence
	initial begin
		{ref_clk_i, wr_i, rd_i, put_i, drain_i, ovr, sh} = 7'h00;
		{addr_i, wdata_i, put_char_i, modem_delta_i} = 26'h0;
		modem_state_i = 4'($random(seed));
		rst_i = 1'b1;
		cyc(6);
		rst_i = 1'b0;
		rdc(3'h1, 8'h00);
		rdc(3'h2, 8'h01);
		rdc(3'h5, lsr_e());
		wr(3'h3, 8'hbf);
		wr(3'h2, 8'h10);
		rdc(3'h2, 8'h10);
		for (i = 4; i < 8; i++) begin
			fc[i] = 8'($random(seed));
			wr(3'(i), fc[i]);
		end
		for (i = 4; i < 8; i++) rdc(3'(i), fc[i]);
		wr(3'h3, 8'h03);
		rdc(3'h4, 8'h00);
		wr(3'h1, 8'h10);
		chk("sleep", 8'h01, slp);
		wr(3'h1, 8'h00);
		wr(3'h3, 8'hbf);
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h03);
		wr(3'h1, 8'hf0);
		rdc(3'h1, 8'h00);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h05);
		wr(3'h1, 8'h00);
		rdc(3'h0, 8'h05);
		rdc(3'h1, 8'h00);
		wr(3'h3, 8'h03);
		n = 0;
		cyc(10);
		repeat (100) begin
			cyc(1);
			n += tick;
		end
		chk("ticks", 8'd20, n[7:0]);
		wr(3'h1, 8'h05);
		put(11'h100 | 11'($random(seed) & 8'hff));
		chk("irq", 8'h01, irq_o);
		rdc(3'h5, lsr_e());
		rdc(3'h2, 8'h04);
		pop_one();
		rdc(3'h2, 8'h06);
		rdc(3'h5, lsr_e());
		chk("irq", 8'h00, irq_o);
		wr(3'h1, 8'h01);
		for (k = 0; k < 4; k++) begin
			wr(3'h2, {k[1:0], 6'h03});
			cyc(1);
			rq.delete();
			for (i = 0; i < tl[k]; i++) begin
				chk("irq", 8'h00, irq_o);
				put(11'($random(seed) & 8'hff));
			end
			chk("irq", 8'h01, irq_o);
			rdc(3'h2, 8'hc4);
			pop_one();
			chk("irq", 8'h00, irq_o);
			rdc(3'h2, 8'hc1);
		end
		wr(3'h1, 8'h00);
		for (i = 0; i < 3; i++) put(11'($random(seed) & 8'hff));
		chk("irq", 8'h00, irq_o);
		rdc(3'h5, lsr_e());
		wr(3'h1, 8'h04);
		put(11'h055);
		chk("irq", 8'h01, irq_o);
		rdc(3'h5, lsr_e());
		ovr = 1'b0;
		chk("irq", 8'h00, irq_o);
		pop_one();
		put(11'h200 | 11'($random(seed) & 8'hff));
		rdc(3'h5, lsr_e());
		wr(3'h2, 8'h03);
		cyc(1);
		rq.delete();
		wr(3'h1, 8'h02);
		rdc(3'h2, 8'hc1);
		chk("irq", 8'h00, irq_o);
		wr(3'h0, 8'($random(seed)));
		txc++;
		cyc(1);
		rdc(3'h5, lsr_e());
		drain();
		chk("irq", 8'h01, irq_o);
		rdc(3'h5, lsr_e());
		rdc(3'h2, 8'hc2);
		chk("irq", 8'h00, irq_o);
		drain();
		rdc(3'h5, lsr_e());
		wr(3'h1, 8'h08);
		modem_delta_i = 4'($random(seed)) | 4'h1;
		cyc(1);
		modem_delta_i = 4'h0;
		cyc(1);
		chk("irq", 8'h01, irq_o);
		rdc(3'h6, {modem_state_i, 4'h0});
		chk("irq", 8'h00, irq_o);
		wr(3'h2, 8'hc0);
		rdc(3'h2, 8'h01);
		tally_and_finish();
	end
endmodule
bind uart_ier_regs uart_ier_regs_chk u_uart_ier_regs_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.rx_level_i(rx_level_i), .rx_pop_o(rx_pop_o), .tx_push_o(tx_push_o),
	.tx_data_o(tx_data_o), .rx_fifo_reset_o(rx_fifo_reset_o), .fifo_enable_o(fifo_enable_o),
	.sleep_enable_o(sleep_enable_o), .flow_ctrl_o(flow_ctrl_o), .irq_o(irq_o));

//--- verilog/rate_generator.sv
/*
 * Sixteen-bit rate counter producing a one-cycle tick every divisor cycles.
 * Assumes a synchronous active-high reset and divisor zero treated as one.
 */
`timescale 1ns/100ps
module rate_generator (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	rate_if.gen       rate
);
	logic [15:0] count_r;

	// =====================================================================
	// Counter reloads from the divisor and pulses the tick on expiry.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			count_r   <= 16'h0000;
			rate.tick <= 1'b0;
		end else if (count_r <= 16'h0001) begin
			count_r   <= rate.divisor;
			rate.tick <= 1'b1;
		end else begin
			count_r   <= count_r - 16'h0001;
			rate.tick <= 1'b0;
		end
	end
endmodule

//--- verilog/rate_if.sv
/*
 * Interface carrying divisor and tick between the channel and its rate counter.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
interface rate_if;
	logic [15:0] divisor;
	logic        tick;
	modport ctrl (output divisor, input tick);
	modport gen  (input divisor, output tick);
endinterface

//--- verilog/uart_ier_pkg.sv
/*
 * Constants for the interrupt-enable and enhanced register block of one UART channel.
 * Assumes a 3-bit register address and an 8-bit data bus from the host.
 */
package uart_ier_pkg;
	// =====================================================================
	// Register addresses.
	localparam logic [2:0] ADDR_DATA       = 3'h0;
	localparam logic [2:0] ADDR_IER        = 3'h1;
	localparam logic [2:0] ADDR_ISR_FCR    = 3'h2;
	localparam logic [2:0] ADDR_LCR        = 3'h3;
	localparam logic [2:0] ADDR_MCR        = 3'h4;
	localparam logic [2:0] ADDR_LSR        = 3'h5;
	localparam logic [2:0] ADDR_MSR        = 3'h6;
	localparam logic [2:0] ADDR_SPR        = 3'h7;
	localparam logic [2:0] ADDR_EFR        = 3'h2;
	localparam logic [2:0] ADDR_RESUME1    = 3'h4;
	localparam logic [2:0] ADDR_RESUME2    = 3'h5;
	localparam logic [2:0] ADDR_PAUSE1     = 3'h6;
	localparam logic [2:0] ADDR_PAUSE2     = 3'h7;
	// =====================================================================
	// Field positions and key values.
	localparam logic [7:0] LCR_ENH_KEY     = 8'hbf;
	localparam int         LCR_DIV_BIT     = 7;
	localparam int         EFR_ENH_BIT     = 4;
	localparam int         FCR_EN_BIT      = 0;
	localparam logic [7:0] IER_LOW_MASK    = 8'h0f;
	localparam logic [7:0] MCR_LOW_MASK    = 8'h1f;
	localparam logic [7:0] ZERO8           = 8'h00;
	localparam logic [15:0] DIV_RESET      = 16'h0001;
	// =====================================================================
	// Interrupt identification codes for status bits 5..0.
	localparam logic [5:0] ID_NONE         = 6'h01;
	localparam logic [5:0] ID_LINE         = 6'h06;
	localparam logic [5:0] ID_RXRDY        = 6'h04;
	localparam logic [5:0] ID_TXRDY        = 6'h02;
	localparam logic [5:0] ID_MODEM        = 6'h00;
	localparam logic [4:0] TRIG_1          = 5'h01;
	localparam logic [4:0] TRIG_4          = 5'h04;
	localparam logic [4:0] TRIG_8          = 5'h08;
	localparam logic [4:0] TRIG_14         = 5'h0e;
endpackage

//--- verilog/uart_ier_regs.sv
/*
 * Interrupt enable, status and enhanced registers of one UART channel.
 * Assumes the host bus is synchronous to ref_clk_i and that FIFO state comes
 * from the neighbouring transmitter and receiver logic.
 */
`timescale 1ns/100ps
// Behaviour
// - Upper enable bits gated by enhanced bit 4.
// - Flow characters mapped only when line control 0xBF.
// - Sixteen-bit counter from divisor bytes sets rate.
// - Divisor bytes visible only when line control bit 7.
// - Receive interrupt at trigger, drops below it.
// - Status shows trigger, clears with interrupt.
// - Data ready set on push, cleared when empty.
// - Overrun sets line status bit 1.
// - Bits 2-4 report head character errors.
// - Bit 5 transmit empty; bit 6 both empty.
// - Bit 7 when any FIFO character errored.
// - Enable 0 gates receive data interrupt.
// - Enable 1 gates transmit empty interrupt.
// - Enable 2 gates line status interrupt.
// - Overrun interrupts immediately on reception.
// - Other errors interrupt when character read.
// - Enable 3 gates modem status interrupt.
// - Sleep enable honoured only with enhanced bit.
// - Status reports enabled sources, masks others.
// - Status bit 0 high when nothing pending.
// - FIFOs run only while control bit 0 set.
module uart_ier_regs (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic [4:0] rx_level_i,
	input  wire logic       rx_push_i,
	input  wire logic [7:0] rx_head_data_i,
	input  wire logic       rx_head_parity_i,
	input  wire logic       rx_head_framing_i,
	input  wire logic       rx_head_break_i,
	input  wire logic       rx_any_error_i,
	input  wire logic       rx_overrun_i,
	input  wire logic       tx_fifo_empty_i,
	input  wire logic       tx_shift_empty_i,
	input  wire logic [3:0] modem_delta_i,
	input  wire logic [3:0] modem_state_i,
	output logic            rx_pop_o,
	output logic            tx_push_o,
	output logic      [7:0] tx_data_o,
	output logic            rx_fifo_reset_o,
	output logic            tx_fifo_reset_o,
	output logic            fifo_enable_o,
	output logic            sleep_enable_o,
	output logic            baud_tick_o,
	output logic      [7:0] flow_ctrl_o,
	output logic            irq_o
);
	logic [7:0] interrupt_enable_r;
	logic [7:0] enhanced_feature_ctrl_r;
	logic [7:0] flow_resume_char_1_r;
	logic [7:0] flow_resume_char_2_r;
	logic [7:0] flow_pause_char_1_r;
	logic [7:0] flow_pause_char_2_r;
	logic [7:0] fifo_control_r;
	logic [7:0] line_control_r;
	logic [7:0] modem_control_r;
	logic [7:0] scratch_r;
	logic [7:0] divisor_low_r;
	logic [7:0] divisor_high_byte_r;
	logic       overrun_r;
	logic       line_irq_r;
	logic       tx_irq_r;
	logic       modem_irq_r;
	logic       rx_ready_r;
	logic       tx_empty_d_r;
	logic       enh_map;
	logic       div_map;
	logic       enh_on;
	logic [4:0] trigger;
	logic       rx_trig;
	logic       rx_src;
	logic [5:0] int_id;
	logic       pending;
	logic [7:0] line_status;
	logic       head_err;
	logic       rd_line;
	logic       rd_isr;
	logic       wr_thr;
	logic       rd_rhr;
	logic       rd_msr;
	rate_if     rate ();

	// Decodes a host access to one address in the plain register map.
	function automatic logic hit(input logic [2:0] a, input logic [2:0] want,
	                             input logic strobe, input logic blocked);
		hit = strobe && (a == want) && !blocked;
	endfunction

	// =====================================================================
	// Access decode.
	// Enhanced map and divisor map overlay the plain registers.
	assign enh_map = (line_control_r == uart_ier_pkg::LCR_ENH_KEY);
	assign div_map = line_control_r[uart_ier_pkg::LCR_DIV_BIT] && !enh_map;
	assign enh_on  = enhanced_feature_ctrl_r[uart_ier_pkg::EFR_ENH_BIT];
	assign rd_line = hit(addr_i, uart_ier_pkg::ADDR_LSR, rd_i, enh_map);
	assign rd_isr  = hit(addr_i, uart_ier_pkg::ADDR_ISR_FCR, rd_i,
	                     enh_map || line_control_r[uart_ier_pkg::LCR_DIV_BIT]);
	assign wr_thr  = hit(addr_i, uart_ier_pkg::ADDR_DATA, wr_i,
	                     line_control_r[uart_ier_pkg::LCR_DIV_BIT]);
	assign rd_rhr  = hit(addr_i, uart_ier_pkg::ADDR_DATA, rd_i,
	                     line_control_r[uart_ier_pkg::LCR_DIV_BIT]);
	assign rd_msr  = hit(addr_i, uart_ier_pkg::ADDR_MSR, rd_i, enh_map);
	assign rx_pop_o  = rd_rhr;
	assign tx_push_o = wr_thr;

	// =====================================================================
	// Enhanced registers, reachable only under the key value.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			enhanced_feature_ctrl_r <= uart_ier_pkg::ZERO8;
			flow_resume_char_1_r    <= uart_ier_pkg::ZERO8;
			flow_resume_char_2_r    <= uart_ier_pkg::ZERO8;
			flow_pause_char_1_r     <= uart_ier_pkg::ZERO8;
			flow_pause_char_2_r     <= uart_ier_pkg::ZERO8;
		end else if (wr_i && enh_map) begin
			case (addr_i)
				uart_ier_pkg::ADDR_EFR:     enhanced_feature_ctrl_r <= wdata_i;
				uart_ier_pkg::ADDR_RESUME1: flow_resume_char_1_r    <= wdata_i;
				uart_ier_pkg::ADDR_RESUME2: flow_resume_char_2_r    <= wdata_i;
				uart_ier_pkg::ADDR_PAUSE1:  flow_pause_char_1_r     <= wdata_i;
				uart_ier_pkg::ADDR_PAUSE2:  flow_pause_char_2_r     <= wdata_i;
				default: ;
			endcase
		end
	end

	// =====================================================================
	// Line control is writable in every map so the key can be left again.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			line_control_r <= uart_ier_pkg::ZERO8;
		end else if (wr_i && addr_i == uart_ier_pkg::ADDR_LCR) begin
			line_control_r <= wdata_i;
		end
	end

	// =====================================================================
	// Plain registers; upper enable and modem bits need the enhanced bit.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			interrupt_enable_r <= uart_ier_pkg::ZERO8;
			modem_control_r    <= uart_ier_pkg::ZERO8;
			scratch_r          <= uart_ier_pkg::ZERO8;
		end else if (wr_i && !enh_map && !div_map) begin
			if (addr_i == uart_ier_pkg::ADDR_IER) begin
				interrupt_enable_r <= enh_on ? wdata_i :
				                      ((interrupt_enable_r & ~uart_ier_pkg::IER_LOW_MASK)
				                      | (wdata_i & uart_ier_pkg::IER_LOW_MASK));
			end
			if (addr_i == uart_ier_pkg::ADDR_MCR) begin
				modem_control_r <= enh_on ? wdata_i :
				                   ((modem_control_r & ~uart_ier_pkg::MCR_LOW_MASK)
				                   | (wdata_i & uart_ier_pkg::MCR_LOW_MASK));
			end
			if (addr_i == uart_ier_pkg::ADDR_SPR) begin
				scratch_r <= wdata_i;
			end
		end
	end

	// =====================================================================
	// FIFO control; other bits take effect only with the enable bit set.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fifo_control_r  <= uart_ier_pkg::ZERO8;
			rx_fifo_reset_o <= 1'b0;
			tx_fifo_reset_o <= 1'b0;
		end else if (wr_i && addr_i == uart_ier_pkg::ADDR_ISR_FCR && !enh_map
		             && !line_control_r[uart_ier_pkg::LCR_DIV_BIT]) begin
			if (wdata_i[uart_ier_pkg::FCR_EN_BIT]) begin
				fifo_control_r  <= {wdata_i[7:6], enh_on ? wdata_i[5:4] : 2'b00,
				                    wdata_i[3], 2'b00, 1'b1};
				rx_fifo_reset_o <= wdata_i[1];
				tx_fifo_reset_o <= wdata_i[2];
			end else begin
				fifo_control_r  <= uart_ier_pkg::ZERO8;
				rx_fifo_reset_o <= 1'b0;
				tx_fifo_reset_o <= 1'b0;
			end
		end else begin
			rx_fifo_reset_o <= 1'b0;
			tx_fifo_reset_o <= 1'b0;
		end
	end

	// =====================================================================
	// Divisor bytes, reachable only with the divisor bit set.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			divisor_low_r       <= uart_ier_pkg::DIV_RESET[7:0];
			divisor_high_byte_r <= uart_ier_pkg::DIV_RESET[15:8];
		end else if (wr_i && div_map) begin
			if (addr_i == uart_ier_pkg::ADDR_DATA) begin
				divisor_low_r <= wdata_i;
			end
			if (addr_i == uart_ier_pkg::ADDR_IER) begin
				divisor_high_byte_r <= wdata_i;
			end
		end
	end

	// Rate counter fed from both divisor bytes.
	assign rate.divisor = {divisor_high_byte_r, divisor_low_r};
	assign baud_tick_o  = rate.tick;
	rate_generator u_rate (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.rate      (rate.gen)
	);

	// =====================================================================
	// Receive trigger level and data-ready source.
	always_comb begin
		case (fifo_control_r[7:6])
			2'b00:   trigger = uart_ier_pkg::TRIG_1;
			2'b01:   trigger = uart_ier_pkg::TRIG_4;
			2'b10:   trigger = uart_ier_pkg::TRIG_8;
			2'b11:   trigger = uart_ier_pkg::TRIG_14;
			default: trigger = uart_ier_pkg::TRIG_1;
		endcase
	end
	assign fifo_enable_o = fifo_control_r[uart_ier_pkg::FCR_EN_BIT];
	assign rx_trig = fifo_enable_o ? (rx_level_i >= trigger)
	                               : (rx_level_i != 5'h00);
	assign rx_src  = rx_trig && interrupt_enable_r[0];

	// Data ready sets on a push and holds until the FIFO is empty.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_ready_r <= 1'b0;
		end else if (rx_push_i) begin
			rx_ready_r <= 1'b1;
		end else if (rx_level_i == 5'h00) begin
			rx_ready_r <= 1'b0;
		end
	end

	// =====================================================================
	// Overrun flag; set wins over the clear by a line status read.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			overrun_r <= 1'b0;
		end else if (rx_overrun_i) begin
			overrun_r <= 1'b1;
		end else if (rd_line) begin
			overrun_r <= 1'b0;
		end
	end

	// Head errors count only once the character stands at the read position.
	assign head_err    = rx_head_parity_i || rx_head_framing_i || rx_head_break_i;
	assign line_status = {rx_any_error_i,
	                      tx_fifo_empty_i && tx_shift_empty_i,
	                      tx_fifo_empty_i,
	                      rx_head_break_i, rx_head_framing_i, rx_head_parity_i,
	                      overrun_r, rx_ready_r};

	// =====================================================================
	// Line status interrupt: overrun at once, other errors when the errored head character is read.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			line_irq_r <= 1'b0;
		end else if (rx_overrun_i) begin
			line_irq_r <= 1'b1;
		end else if (rd_rhr && head_err) begin
			line_irq_r <= 1'b1;
		end else if (rd_line) begin
			line_irq_r <= 1'b0;
		end
	end

	// =====================================================================
	// Transmit ready interrupt on each transition to empty.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_empty_d_r <= 1'b1;
			tx_irq_r     <= 1'b0;
		end else begin
			tx_empty_d_r <= tx_fifo_empty_i;
			if (tx_fifo_empty_i && !tx_empty_d_r) begin
				tx_irq_r <= 1'b1;
			end else if (wr_thr || rd_isr) begin
				tx_irq_r <= 1'b0;
			end
		end
	end

	// Modem interrupt on any delta, cleared by reading modem status.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			modem_irq_r <= 1'b0;
		end else if (modem_delta_i != 4'h0) begin
			modem_irq_r <= 1'b1;
		end else if (rd_msr) begin
			modem_irq_r <= 1'b0;
		end
	end

	// =====================================================================
	// Priority encoding of enabled sources only.
	always_comb begin
		if (line_irq_r && interrupt_enable_r[2]) begin
			int_id = uart_ier_pkg::ID_LINE;
		end else if (rx_src) begin
			int_id = uart_ier_pkg::ID_RXRDY;
		end else if (tx_irq_r && interrupt_enable_r[1]) begin
			int_id = uart_ier_pkg::ID_TXRDY;
		end else if (modem_irq_r && interrupt_enable_r[3]) begin
			int_id = uart_ier_pkg::ID_MODEM;
		end else begin
			int_id = uart_ier_pkg::ID_NONE;
		end
	end
	assign pending = !int_id[0];
	assign irq_o   = pending;

	// Sleep honoured only with the enhanced bit.
	assign sleep_enable_o = interrupt_enable_r[4] && enh_on;
	assign flow_ctrl_o    = enhanced_feature_ctrl_r;
	assign tx_data_o      = wdata_i;

	// =====================================================================
	// Read data mux, registered.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_o <= uart_ier_pkg::ZERO8;
		end else if (rd_i) begin
			if (enh_map) begin
				case (addr_i)
					uart_ier_pkg::ADDR_EFR:     rdata_o <= enhanced_feature_ctrl_r;
					uart_ier_pkg::ADDR_RESUME1: rdata_o <= flow_resume_char_1_r;
					uart_ier_pkg::ADDR_RESUME2: rdata_o <= flow_resume_char_2_r;
					uart_ier_pkg::ADDR_PAUSE1:  rdata_o <= flow_pause_char_1_r;
					uart_ier_pkg::ADDR_PAUSE2:  rdata_o <= flow_pause_char_2_r;
					uart_ier_pkg::ADDR_LCR:     rdata_o <= line_control_r;
					default:                    rdata_o <= uart_ier_pkg::ZERO8;
				endcase
			end else begin
				case (addr_i)
					uart_ier_pkg::ADDR_DATA:
						rdata_o <= div_map ? divisor_low_r : rx_head_data_i;
					uart_ier_pkg::ADDR_IER:
						rdata_o <= div_map ? divisor_high_byte_r : interrupt_enable_r;
					uart_ier_pkg::ADDR_ISR_FCR:
						rdata_o <= {fifo_enable_o, fifo_enable_o, int_id};
					uart_ier_pkg::ADDR_LCR: rdata_o <= line_control_r;
					uart_ier_pkg::ADDR_MCR: rdata_o <= modem_control_r;
					uart_ier_pkg::ADDR_LSR: rdata_o <= line_status;
					uart_ier_pkg::ADDR_MSR: rdata_o <= {modem_state_i, modem_delta_i};
					uart_ier_pkg::ADDR_SPR: rdata_o <= scratch_r;
					default:                rdata_o <= uart_ier_pkg::ZERO8;
				endcase
			end
		end
	end
endmodule
